// ---- rtl/vftle_map.svh ----
// register offsets, field positions and reset values of the frame timer
`ifndef VFTLE_MAP_SVH
`define VFTLE_MAP_SVH

// register byte offsets, one aligned word each
`define VFTLE_OFS_HORIZ_LINE_TOTAL     8'h00
`define VFTLE_OFS_HORIZ_SYNC_END       8'h04
`define VFTLE_OFS_HORIZ_BLANK_END      8'h08
`define VFTLE_OFS_HORIZ_BLANK_START    8'h0C
`define VFTLE_OFS_VERT_FRAME_TOTAL     8'h10
`define VFTLE_OFS_VERT_SYNC_END        8'h14
`define VFTLE_OFS_VERT_BLANK_END       8'h18
`define VFTLE_OFS_VERT_BLANK_START     8'h1C
`define VFTLE_OFS_AREA_LINE_EVENT_POS  8'h20
`define VFTLE_OFS_BLANK_LINE_EVENT_POS 8'h24
`define VFTLE_OFS_FRAME_MEMORY_CONTROL 8'h28
`define VFTLE_OFS_TAP_MASK             8'h2C
`define VFTLE_OFS_NEXT_LINE_ADDRESS    8'h30
`define VFTLE_OFS_CURRENT_LINE_ADDRESS 8'h34
`define VFTLE_OFS_FIELD0_START_ADDRESS 8'h38
`define VFTLE_OFS_LINE_ADDR_INCREMENT  8'h3C
`define VFTLE_OFS_SHIFT_REG_INCREMENT  8'h40
`define VFTLE_OFS_TIMER_STATUS         8'h44

// frame memory control fields
`define VFTLE_FMC_TIMER_ENABLE_BIT     0
`define VFTLE_FMC_EVENT_MODE_LSB       2
`define VFTLE_FMC_UNBLANKED_DIS_BIT    4
`define VFTLE_FMC_HALF_SHIFT_BIT       14

// status fields
`define VFTLE_STS_HSYNC_BIT            0
`define VFTLE_STS_VSYNC_BIT            1
`define VFTLE_STS_HBLANK_BIT           2
`define VFTLE_STS_VBLANK_BIT           3
`define VFTLE_STS_VERT_COUNTER_LSB           16

// reset values
`define VFTLE_RST_WORD                 32'h0000_0000
`define VFTLE_EVENT_MODE_ALL           2'h0

`endif

// ---- rtl/vftle_pkg.sv ----
// types shared by the frame timer and line event scheduler
package vftle_pkg;

    // register bus request from software
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } vftle_reg_req_t;

    // kind of serial row transfer asked of the memory
    typedef enum logic [1:0] {
        VFTLE_XFER_FIELD_READ,
        VFTLE_XFER_LINE_READ,
        VFTLE_XFER_SPLIT_WRITE
    } vftle_xfer_kind_t;

    // transfer request toward video memory
    typedef struct packed {
        logic             valid;
        vftle_xfer_kind_t kind;
        logic [31:0]      addr;
    } vftle_xfer_t;

    // display timing levels
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic hblank;
        logic vblank;
    } vftle_timing_t;

endpackage

// ---- rtl/vftle_top.sv ----
// frame timer with sync and blanking generation and line event scheduling
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "vftle_map.svh"

module vftle_top #(
    parameter int CNT_W = 16  // width of both counters and limit registers
) (
    // clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     sys_rst_in,
    // register port
    input  wire vftle_pkg::vftle_reg_req_t reg_req_in,
    output logic [31:0]                   reg_rdata_out,
    // shift register overflow pin from the serial clock side
    input  wire logic                     shift_overflow_in,
    // display timing and transfer requests
    output vftle_pkg::vftle_timing_t      timing_out,
    output vftle_pkg::vftle_xfer_t        xfer_out
);
    import vftle_pkg::*;

    // counters must fit the limit fields and leave room in status
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("vftle_top: CNT_W must lie in 2..16");
    end

    // software registers
    logic [CNT_W-1:0] horiz_line_total;      // cycles per line minus one
    logic [CNT_W-1:0] horiz_sync_end;        // last sync cycle
    logic [CNT_W-1:0] horiz_blank_end;       // last blank cycle after sync
    logic [CNT_W-1:0] horiz_blank_start;     // first blank cycle before total
    logic [CNT_W-1:0] vert_frame_total;      // lines per frame minus one
    logic [CNT_W-1:0] vert_sync_end;         // twice sync lines minus one
    logic [CNT_W-1:0] vert_blank_end;        // last blank line
    logic [CNT_W-1:0] vert_blank_start;      // first blank line
    logic [CNT_W-1:0] area_line_event_pos;   // event tied to active area
    logic [CNT_W-1:0] blank_line_event_pos;  // event tied to blanking
    logic [31:0]      frame_memory_control;  // enable, mode and half select
    logic [31:0]      shift_register_tap_mask;
    logic [31:0]      next_line_address;
    logic [31:0]      current_line_address;
    logic [31:0]      field0_start_address;
    logic [31:0]      line_address_increment;
    logic [31:0]      shift_register_increment;

    // counters and overflow capture
    logic [CNT_W-1:0] horiz_counter;         // frame-clock cycles since sync
    logic [CNT_W-1:0] vert_counter;          // lines since vertical sync
    logic [2:0]       ovf_sync;              // two-stage sync plus edge stage
    logic             ovf_pending;           // overflow waiting for its slot

    // control field decode
    wire              timer_enable            = frame_memory_control[`VFTLE_FMC_TIMER_ENABLE_BIT];
    wire [1:0]        event_mode_select       = frame_memory_control[`VFTLE_FMC_EVENT_MODE_LSB +: 2];
    wire              unblanked_event_disable = frame_memory_control[`VFTLE_FMC_UNBLANKED_DIS_BIT];
    wire              half_shift_select       = frame_memory_control[`VFTLE_FMC_HALF_SHIFT_BIT];
    wire              mode_all_events         = (event_mode_select == `VFTLE_EVENT_MODE_ALL);

    // register address decode, used for both writes and reads
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // horizontal and vertical wrap points
    // direct cycle compare
    wire              h_at_total = (horiz_counter == horiz_line_total);
    wire              v_at_total = (vert_counter == vert_frame_total);

    wire [CNT_W-1:0]  next_horiz = h_at_total ? '0 : CNT_W'(horiz_counter + 1'b1);
    wire [CNT_W-1:0]  next_vert  = !h_at_total ? vert_counter :
                                   (v_at_total ? '0 : CNT_W'(vert_counter + 1'b1));

    // timing levels from the counters
    // sync begins at count zero
    wire              hsync_lvl  = (horiz_counter <= horiz_sync_end);
    wire              vsync_lvl  = (vert_counter <= (vert_sync_end >> 1));
    // blank from start value to total and from zero to end value
    wire              hblank_lvl = (horiz_counter >= horiz_blank_start) ||
                                   (horiz_counter <= horiz_blank_end);
    wire              vblank_lvl = (vert_counter >= vert_blank_start) ||
                                   (vert_counter <= vert_blank_end);

    // event detection
    // disable bit picks event register
    wire [CNT_W-1:0]  event_pos    = unblanked_event_disable ? area_line_event_pos
                                                             : blank_line_event_pos;
    wire              line_event   = timer_enable && (horiz_counter == event_pos);
    // field start only in mode zero
    wire              field_event  = timer_enable && mode_all_events &&
                                     (horiz_counter == '0) && (vert_counter == '0);
    wire              ovf_edge     = ovf_sync[1] && !ovf_sync[2];
    wire              ovf_event    = timer_enable && mode_all_events && (ovf_pending || ovf_edge);
    // field start beats line event, both beat overflow
    wire              ovf_issue    = ovf_event && !field_event && !line_event;

    // split write address for the overflow transfer
    // mask clears the tap bits
    wire [31:0]       tap_cleared  = current_line_address & ~shift_register_tap_mask;
    wire [31:0]       split_base   = tap_cleared - shift_register_increment;
    wire [31:0]       split_addr   = half_shift_select ? (split_base ^ {shift_register_increment[30:0], 1'b0})
                                                       : split_base;

    // next transfer request, purely combinational selection
    wire              next_xfer_valid = field_event || line_event || ovf_issue;
    wire vftle_xfer_kind_t next_xfer_kind = field_event ? VFTLE_XFER_FIELD_READ :
                                           (line_event ? VFTLE_XFER_LINE_READ : VFTLE_XFER_SPLIT_WRITE);
    wire [31:0]       next_xfer_addr  = field_event ? field0_start_address :
                                       (line_event ? next_line_address : split_addr);

    // software writes of each register
    wire              wr = reg_req_in.wr;
    wire [7:0]        wa = reg_req_in.addr;
    wire [31:0]       wd = reg_req_in.wdata;

    // read data selection, unmapped offsets read zero
    logic [31:0]      next_rdata;
    always_comb begin
        next_rdata = `VFTLE_RST_WORD;
        if (hit(wa, `VFTLE_OFS_HORIZ_LINE_TOTAL))     next_rdata = 32'(horiz_line_total);
        if (hit(wa, `VFTLE_OFS_HORIZ_SYNC_END))       next_rdata = 32'(horiz_sync_end);
        if (hit(wa, `VFTLE_OFS_HORIZ_BLANK_END))      next_rdata = 32'(horiz_blank_end);
        if (hit(wa, `VFTLE_OFS_HORIZ_BLANK_START))    next_rdata = 32'(horiz_blank_start);
        if (hit(wa, `VFTLE_OFS_VERT_FRAME_TOTAL))     next_rdata = 32'(vert_frame_total);
        if (hit(wa, `VFTLE_OFS_VERT_SYNC_END))        next_rdata = 32'(vert_sync_end);
        if (hit(wa, `VFTLE_OFS_VERT_BLANK_END))       next_rdata = 32'(vert_blank_end);
        if (hit(wa, `VFTLE_OFS_VERT_BLANK_START))     next_rdata = 32'(vert_blank_start);
        if (hit(wa, `VFTLE_OFS_AREA_LINE_EVENT_POS))  next_rdata = 32'(area_line_event_pos);
        if (hit(wa, `VFTLE_OFS_BLANK_LINE_EVENT_POS)) next_rdata = 32'(blank_line_event_pos);
        if (hit(wa, `VFTLE_OFS_FRAME_MEMORY_CONTROL)) next_rdata = frame_memory_control;
        if (hit(wa, `VFTLE_OFS_TAP_MASK))             next_rdata = shift_register_tap_mask;
        if (hit(wa, `VFTLE_OFS_NEXT_LINE_ADDRESS))    next_rdata = next_line_address;
        if (hit(wa, `VFTLE_OFS_CURRENT_LINE_ADDRESS)) next_rdata = current_line_address;
        if (hit(wa, `VFTLE_OFS_FIELD0_START_ADDRESS)) next_rdata = field0_start_address;
        if (hit(wa, `VFTLE_OFS_LINE_ADDR_INCREMENT))  next_rdata = line_address_increment;
        if (hit(wa, `VFTLE_OFS_SHIFT_REG_INCREMENT))  next_rdata = shift_register_increment;
        // status shows the live vertical counter and levels
        if (hit(wa, `VFTLE_OFS_TIMER_STATUS)) begin
            next_rdata[`VFTLE_STS_HSYNC_BIT]  = timing_out.hsync;
            next_rdata[`VFTLE_STS_VSYNC_BIT]  = timing_out.vsync;
            next_rdata[`VFTLE_STS_HBLANK_BIT] = timing_out.hblank;
            next_rdata[`VFTLE_STS_VBLANK_BIT] = timing_out.vblank;
            next_rdata[`VFTLE_STS_VERT_COUNTER_LSB +: CNT_W] = vert_counter;
        end
        if (!reg_req_in.rd) next_rdata = `VFTLE_RST_WORD;
    end

    // timing limit registers, plain storage
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            horiz_line_total     <= '0;
            horiz_sync_end       <= '0;
            horiz_blank_end      <= '0;
            horiz_blank_start    <= '0;
            vert_frame_total     <= '0;
            vert_sync_end        <= '0;
            vert_blank_end       <= '0;
            vert_blank_start     <= '0;
            area_line_event_pos  <= '0;
            blank_line_event_pos <= '0;
        end else if (wr) begin
            if (hit(wa, `VFTLE_OFS_HORIZ_LINE_TOTAL))     horiz_line_total     <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_HORIZ_SYNC_END))       horiz_sync_end       <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_HORIZ_BLANK_END))      horiz_blank_end      <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_HORIZ_BLANK_START))    horiz_blank_start    <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_VERT_FRAME_TOTAL))     vert_frame_total     <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_VERT_SYNC_END))        vert_sync_end        <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_VERT_BLANK_END))       vert_blank_end       <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_VERT_BLANK_START))     vert_blank_start     <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_AREA_LINE_EVENT_POS))  area_line_event_pos  <= wd[CNT_W-1:0];
            if (hit(wa, `VFTLE_OFS_BLANK_LINE_EVENT_POS)) blank_line_event_pos <= wd[CNT_W-1:0];
        end
    end

    // control and static address registers
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            frame_memory_control     <= `VFTLE_RST_WORD;
            shift_register_tap_mask  <= `VFTLE_RST_WORD;
            field0_start_address     <= `VFTLE_RST_WORD;
            line_address_increment   <= `VFTLE_RST_WORD;
            shift_register_increment <= `VFTLE_RST_WORD;
        end else if (wr) begin
            // whole word taken, bits 0, 2 to 3, 4 and 14 live
            if (hit(wa, `VFTLE_OFS_FRAME_MEMORY_CONTROL)) frame_memory_control     <= wd;
            if (hit(wa, `VFTLE_OFS_TAP_MASK))             shift_register_tap_mask  <= wd;
            if (hit(wa, `VFTLE_OFS_FIELD0_START_ADDRESS)) field0_start_address     <= wd;
            if (hit(wa, `VFTLE_OFS_LINE_ADDR_INCREMENT))  line_address_increment   <= wd;
            if (hit(wa, `VFTLE_OFS_SHIFT_REG_INCREMENT))  shift_register_increment <= wd;
        end
    end

    // line addresses: hardware advances them, a software write wins
    // because software only loads them while display is idle
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            next_line_address    <= `VFTLE_RST_WORD;
            current_line_address <= `VFTLE_RST_WORD;
        end else begin
            if (field_event) begin
                current_line_address <= field0_start_address;
                next_line_address    <= field0_start_address + line_address_increment;
            end else if (line_event) begin
                current_line_address <= next_line_address;
                next_line_address    <= next_line_address + line_address_increment;
            end
            if (wr && hit(wa, `VFTLE_OFS_NEXT_LINE_ADDRESS))    next_line_address    <= wd;
            if (wr && hit(wa, `VFTLE_OFS_CURRENT_LINE_ADDRESS)) current_line_address <= wd;
        end
    end

    // frame counters, held at zero while the timer is off
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            horiz_counter <= '0;
            vert_counter  <= '0;
        end else if (!timer_enable) begin
            horiz_counter <= '0;
            vert_counter  <= '0;
        end else begin
            horiz_counter <= next_horiz;
            vert_counter  <= next_vert;
        end
    end

    // overflow pin synchroniser; pending flag set wins over clear
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ovf_sync    <= 3'h0;
            ovf_pending <= 1'b0;
        end else begin
            ovf_sync    <= {ovf_sync[1:0], shift_overflow_in};
            ovf_pending <= (ovf_event && !ovf_issue) || (ovf_pending && ovf_edge);
        end
    end

    // registered outputs: timing lags the counters by one cycle
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            timing_out    <= '0;
            xfer_out      <= '0;
            reg_rdata_out <= `VFTLE_RST_WORD;
        end else begin
            timing_out    <= '{hsync: hsync_lvl && timer_enable, vsync: vsync_lvl && timer_enable,
                               hblank: hblank_lvl || !timer_enable, vblank: vblank_lvl || !timer_enable};
            xfer_out      <= '{valid: next_xfer_valid, kind: next_xfer_kind, addr: next_xfer_addr};
            reg_rdata_out <= next_rdata;
        end
    end

endmodule // vftle_top

// ---- verification/vftle_checker.sv ----
// port checker for the frame timer, bound into its top module
`include "vftle_map.svh"
module vftle_checker #(
    parameter int CNT_W = 16  // counter width, as in the design
) (
    // clock and reset
    input wire logic                      core_clk_in,
    input wire logic                      sys_rst_in,
    // register port
    input wire vftle_pkg::vftle_reg_req_t reg_req_in,
    input wire logic [31:0]               reg_rdata_out,
    // overflow pin, timing levels and transfers
    input wire logic                      shift_overflow_in,
    input wire vftle_pkg::vftle_timing_t  timing_out,
    input wire vftle_pkg::vftle_xfer_t    xfer_out
);
    import vftle_pkg::*;
    logic [CNT_W-1:0] h_tot;  // shadow of line total
    logic [CNT_W-1:0] h_se;   // shadow of sync end
    logic [CNT_W-1:0] pos_a;  // shadow of area event position
    logic [CNT_W-1:0] pos_b;  // shadow of blank event position
    logic [31:0]      ctl;    // shadow of control word
    logic [15:0]      run;    // cycles since hsync rose, minus one
    logic             armed;  // a line began since the last write
    wire logic [CNT_W-1:0] wd = reg_req_in.wdata[CNT_W-1:0];  // limit field of a write

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // shadows follow software writes, so limits are known without peeking inside
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {h_tot, h_se, pos_a, pos_b, ctl} <= '0;
        end else if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                `VFTLE_OFS_HORIZ_LINE_TOTAL:     h_tot <= wd;
                `VFTLE_OFS_HORIZ_SYNC_END:       h_se <= wd;
                `VFTLE_OFS_AREA_LINE_EVENT_POS:  pos_a <= wd;
                `VFTLE_OFS_BLANK_LINE_EVENT_POS: pos_b <= wd;
                `VFTLE_OFS_FRAME_MEMORY_CONTROL: ctl <= reg_req_in.wdata;
                default: ;
            endcase
        end
    end

    // line position counter; any write disarms it, since a line cut short proves nothing
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run   <= 16'h0000;
            armed <= 1'b0;
        end else begin
            run   <= $rose(timing_out.hsync) ? 16'h0000 : run + 16'h0001;
            armed <= reg_req_in.wr ? 1'b0 : (armed | $rose(timing_out.hsync));
        end
    end

    line_period_a: assert property (armed && $rose(timing_out.hsync) |-> run[CNT_W-1:0] == h_tot)
        else $error("line length differs from programmed total");
    hsync_width_a: assert property (armed && $fell(timing_out.hsync) |-> run[CNT_W-1:0] == h_se)
        else $error("hsync width differs from sync end");
    vsync_align_a: assert property (armed && $changed(timing_out.vsync) |-> $rose(timing_out.hsync))
        else $error("vsync moved off a line boundary");
    vblank_align_a: assert property (armed && $changed(timing_out.vblank) |-> $rose(timing_out.hsync))
        else $error("vblank moved off a line boundary");
    field_xfer_a: assert property (xfer_out.valid && xfer_out.kind == VFTLE_XFER_FIELD_READ
        |-> $rose(timing_out.hsync) && timing_out.vsync && ctl[3:2] == 2'h0) else $error("field transfer misplaced");
    split_mode_a: assert property (xfer_out.valid && xfer_out.kind == VFTLE_XFER_SPLIT_WRITE
        |-> ctl[3:2] == 2'h0 && ctl[0]) else $error("overflow transfer in wrong mode");
    split_latency_a: assert property ($rose(shift_overflow_in) && ctl[0] && ctl[3:2] == 2'h0
        |-> ##[1:8] (xfer_out.valid && xfer_out.kind == VFTLE_XFER_SPLIT_WRITE)) else $error("overflow transfer late");
    line_xfer_a: assert property (armed && xfer_out.valid && xfer_out.kind == VFTLE_XFER_LINE_READ
        |-> run[CNT_W-1:0] + 1'b1 == (ctl[4] ? pos_a : pos_b)) else $error("line event at wrong position");
endmodule // vftle_checker

bind vftle_top vftle_checker #(.CNT_W(CNT_W)) i_vftle_checker (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .shift_overflow_in(shift_overflow_in),
    .timing_out(timing_out), .xfer_out(xfer_out));

// ---- verification/vftle_vram_model.sv ----
// video memory side model: counts transfers and raises the overflow pin
module vftle_vram_model (
    // clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   sys_rst_in,
    // transfer requests and overflow command
    input  wire vftle_pkg::vftle_xfer_t xfer_in,
    input  wire logic                   overflow_req_in,
    // overflow pin and transfer tally
    output logic                        shift_overflow_out,
    output logic [7:0]                  xfer_count_out
);
    import vftle_pkg::*;
    logic [1:0] hold;  // pin high cycles left, pin low when idle

    // pin held three cycles so the two-stage sync surely sees a single edge
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold           <= 2'h0;
            xfer_count_out <= 8'h00;
        end else begin
            hold           <= overflow_req_in ? 2'h3 : hold - {1'b0, hold != 2'h0};
            xfer_count_out <= xfer_count_out + {7'h00, xfer_in.valid};
        end
    end
    assign shift_overflow_out = hold != 2'h0;
endmodule // vftle_vram_model

// ---- verification/video_frame_timer_line_events_test.sv ----
// self-checking bench: register port, timing levels and transfer schedule
`include "vftle_map.svh"
module video_frame_timer_line_events_test;
    timeunit 1ns;
    timeprecision 100ps;
    import vftle_pkg::*;
    localparam logic [31:0] F0   = 32'h0000_1018;  // field start, tap bits set on purpose
    localparam logic [31:0] LINC = 32'h0000_0100;  // line step
    localparam logic [31:0] SINC = 32'h0000_0010;  // shift register step
    localparam logic [31:0] MASK = 32'h0000_0038;  // tap bits
    logic           core_clk_in = 1'b0;
    logic           sys_rst_in  = 1'b1;
    vftle_reg_req_t req         = '0;
    logic           ovf_req     = 1'b0;           // asks the model for one overflow
    logic [31:0]    rdata;
    vftle_timing_t  tim;
    vftle_xfer_t    xfer;
    logic           ovf_pin;
    logic [7:0]     xcnt;                         // transfers seen by the model
    logic [31:0]    ctl_e       = 32'h0000_4001;  // control word in force
    logic [31:0]    ctl_tab [4] = '{32'h0000_4001, 32'h0000_0011, 32'h0000_4011, 32'h0000_4005};
    logic [31:0]    next_e, cur_e, exp_a;
    logic           hs_prev     = 1'b0;
    int             hb_pos [4]  = '{5, 6, 14, 15};
    int             hcnt, n_xfer, i, n_errors, cmp_count;

    vftle_top i_vftle_top (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .shift_overflow_in(ovf_pin), .timing_out(tim), .xfer_out(xfer));
    vftle_vram_model i_vftle_vram_model (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .xfer_in(xfer),
        .overflow_req_in(ovf_req), .shift_overflow_out(ovf_pin), .xfer_count_out(xcnt));

    always #4 core_clk_in = ~core_clk_in;

    // position in line, zero in the cycle hsync rises
    always @(negedge core_clk_in) begin
        hcnt = (tim.hsync === 1'b1 && hs_prev === 1'b0) ? 0 : hcnt + 1;
        hs_prev = tim.hsync;
    end

    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // settle a cycle: past the falling edge, after the monitor
    task automatic tick();
        @(negedge core_clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_in);
        req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge core_clk_in);
        req.rd <= 1'b0;
        @(negedge core_clk_in);
        compare(rdata, exp);
    endtask
    task automatic wait_h(input int n);
        int k;
        for (k = 0; k < 100 && hcnt != n; k++) tick();
    endtask
    task automatic overflow();
        @(posedge core_clk_in);
        ovf_req <= 1'b1;
        @(posedge core_clk_in);
        ovf_req <= 1'b0;
    endtask
    // next transfer: kind, address and, unless negative, line position
    task automatic wait_xfer(input vftle_xfer_kind_t kd, input logic [31:0] ad, input int pos);
        int k;
        for (k = 0; k < 300; k++) begin
            tick();
            if (xfer.valid === 1'b1) break;
        end
        compare(32'(xfer.kind), 32'(kd));
        compare(xfer.addr, ad);
        if (pos >= 0) compare(32'(hcnt), 32'(pos));
        n_xfer++;
    endtask

    initial begin
        repeat (4) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        reg_rd(`VFTLE_OFS_TIMER_STATUS, 32'h0000_000C);
        reg_wr(`VFTLE_OFS_HORIZ_LINE_TOTAL, 32'h0001_0013);
        reg_rd(`VFTLE_OFS_HORIZ_LINE_TOTAL, 32'h0000_0013);
        reg_rd(8'hFC, 32'h0000_0000);
        reg_wr(`VFTLE_OFS_HORIZ_SYNC_END, 32'h0000_0003);
        reg_wr(`VFTLE_OFS_HORIZ_BLANK_END, 32'h0000_0005);
        reg_wr(`VFTLE_OFS_HORIZ_BLANK_START, 32'h0000_000F);
        reg_wr(`VFTLE_OFS_VERT_FRAME_TOTAL, 32'h0000_0009);
        reg_wr(`VFTLE_OFS_VERT_SYNC_END, 32'h0000_0003);
        reg_wr(`VFTLE_OFS_VERT_BLANK_END, 32'h0000_0002);
        reg_wr(`VFTLE_OFS_VERT_BLANK_START, 32'h0000_0008);
        reg_wr(`VFTLE_OFS_AREA_LINE_EVENT_POS, 32'h0000_0011);
        reg_wr(`VFTLE_OFS_BLANK_LINE_EVENT_POS, 32'h0000_0012);
        reg_wr(`VFTLE_OFS_TAP_MASK, MASK);
        reg_wr(`VFTLE_OFS_NEXT_LINE_ADDRESS, F0);
        reg_wr(`VFTLE_OFS_CURRENT_LINE_ADDRESS, F0);
        reg_wr(`VFTLE_OFS_FIELD0_START_ADDRESS, F0);
        reg_wr(`VFTLE_OFS_LINE_ADDR_INCREMENT, LINC);
        reg_wr(`VFTLE_OFS_SHIFT_REG_INCREMENT, SINC);
        reg_wr(`VFTLE_OFS_FRAME_MEMORY_CONTROL, ctl_e);
        cur_e = F0;
        next_e = F0 + LINC;
        wait_xfer(VFTLE_XFER_FIELD_READ, F0, 0);
        // blanking edges around the back and front porch
        for (i = 0; i < 4; i++) begin
            wait_h(hb_pos[i]);
            compare(32'(tim.hblank), 32'(i == 0 || i == 3));
        end
        // each of five lines: event, then for the first four a control change and one overflow
        for (i = 0; i < 5; i++) begin
            wait_xfer(VFTLE_XFER_LINE_READ, next_e, ctl_e[4] ? 17 : 18);
            compare(32'(tim.vblank), 32'(i <= 2));
            compare(32'(tim.vsync), 32'(i <= 1));
            cur_e = next_e;
            next_e = next_e + LINC;
            if (i == 0) reg_rd(`VFTLE_OFS_FRAME_MEMORY_CONTROL, 32'h0000_4001);
            if (i < 4) begin
                ctl_e = ctl_tab[i];
                reg_wr(`VFTLE_OFS_FRAME_MEMORY_CONTROL, ctl_e);
                wait_h(5);
                overflow();
                exp_a = ((cur_e & ~MASK) - SINC) ^ (ctl_e[14] ? SINC << 1 : 32'h0000_0000);
                if (ctl_e[3:2] == 2'h0) wait_xfer(VFTLE_XFER_SPLIT_WRITE, exp_a, -1);
            end
        end
        repeat (4) tick();
        compare(32'(xcnt), 32'(n_xfer));
        print_verdict();
    end

    // the run needs about 150 cycles; this cuts a hang short
    initial begin
        #50000;
        n_errors++;
        print_verdict();
    end
endmodule // video_frame_timer_line_events_test
